// ---- rcv_pkg.sv ----
// Package with register map, field layout and constants of the calendar value registers.
package rcv_pkg;

   localparam logic [7:0]  ADDR_PAD_CONFIG     = 8'h00;
   localparam logic [7:0]  ADDR_YEAR_VALUE     = 8'h04;
   localparam logic [7:0]  ADDR_MONTH_DAY      = 8'h08;
   localparam logic [7:0]  ADDR_CALIB_CONFIG   = 8'h0C;

   localparam int          PAD_SEC_SEL_BIT     = 1;
   localparam int          PAD_TTL_SEL_BIT     = 0;
   localparam int          CAL_WREN_BIT        = 13;
   localparam int          CAL_OE_BIT          = 10;
   localparam int          CAL_EN_BIT          = 15;

   localparam logic [15:0] PAD_CONFIG_RESET    = 16'h0000;
   localparam logic [15:0] CALIB_CONFIG_RESET  = 16'h0000;
   localparam logic [15:0] PAD_CONFIG_MASK     = 16'h0003;
   localparam logic [15:0] YEAR_MASK           = 16'h00FF;
   localparam logic [15:0] MONTH_DAY_MASK      = 16'h1F3F;
   localparam logic [15:0] CALIB_CONFIG_MASK   = 16'hA400;

   localparam logic [7:0]  LAST_MONTH          = 8'h12;
   localparam logic [7:0]  LAST_YEAR           = 8'h99;

   // Cycles of pclk per half-second tick; shortened in simulation through the top parameter.
   localparam int          HALF_SEC_NS         = 500000000;
   localparam int          CLK_PERIOD_NS       = 100;
   localparam int          HALF_SEC_CYCLES     = HALF_SEC_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic       year_tens_digit_ok;
      logic [3:0] year_tens_digit;
      logic [3:0] year_ones_digit;
   } rcv_year_s;

   typedef struct packed {
      logic       month_tens_digit;
      logic [3:0] month_ones_digit;
      logic [1:0] day_tens_digit;
      logic [3:0] day_ones_digit;
   } rcv_month_day_value_s;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_SETUP  = 2'b01,
      APB_ACCESS = 2'b11
   } rcv_apb_e;

endpackage

// ---- rcv_bcd_inc.sv ----
`timescale 1ns/1ps
// BCD two-digit incrementer with a wrap point and a restart value.
module rcv_bcd_inc (
   input  wire logic [7:0] value,
   input  wire logic [7:0] last,
   input  wire logic [7:0] first,
   output logic      [7:0] result,
   output logic            wrap
);
   always_comb begin
      wrap   = (value == last);
      result = value;
      if (wrap) begin
         result = first;
      end else if (value[3:0] >= 4'h9) begin
         result = {value[7:4] + 4'h1, 4'h0};
      end else begin
         result = {value[7:4], value[3:0] + 4'h1};
      end
   end
endmodule

// ---- rcv_regs.sv ----
`timescale 1ns/1ps
// APB register block holding the calendar year, month and day values and the clock output pad selection.

// Operation
// - The year tens digit is a BCD value 0 to 9 held in year bits 7 to 4.
// - The year ones digit is a BCD value 0 to 9 held in year bits 3 to 0.
// - A year write takes effect only while the clock write enable is 1.
// - The month tens digit is a single bit at month/day bit 12.
// - The month ones digit is a BCD value 0 to 9 in month/day bits 11 to 8.
// - The day tens digit is a BCD value 0 to 3 in month/day bits 5 and 4.
// - The day ones digit is a BCD value 0 to 9 in month/day bits 3 to 0.
// - A month/day write takes effect only while the clock write enable is 1.
// - Unimplemented bits of year, month/day and pad configuration read as zero.
// - Pad configuration bit 1 set routes the seconds tick to the clock output pin.
// - The clock output pin drives only while the output enable bit 10 is set.
// - The clock output pin carries either the alarm signal or the seconds tick.
module rcv_regs #(
   parameter int HALF_SEC_CYCLES = rcv_pkg::HALF_SEC_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        alarm_event,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             clock_out,
   output logic             clock_out_en_n,
   output logic             parport_input_buffer_select
);

   logic [15:0] pad_config_r;
   logic [15:0] calib_config_r;
   logic [7:0]  year_r;
   logic [7:0]  month_r;
   logic [7:0]  day_r;
   logic [31:0] half_cnt_r;
   logic        half_tick_r;
   logic        sec_phase_r;
   logic        alarm_s1_r;
   logic        alarm_s2_r;
   logic        alarm_lvl_r;
   logic        clock_write_enable;
   logic        access;
   logic        wr_year;
   logic        wr_month_day_value;
   logic        day_tick;
   logic [7:0]  day_last;
   logic [7:0]  day_nxt;
   logic [7:0]  month_nxt;
   logic [7:0]  year_nxt;
   logic        day_wrap;
   logic        month_wrap;
   logic        year_wrap;
   logic [15:0] rd_nxt;

   function automatic logic [7:0] days_in_month(input logic [7:0] month, input logic [7:0] year);
      logic leap;
      leap = (year[4] == 1'b0 && (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8)) ||
             (year[4] == 1'b1 && (year[3:0] == 4'h2 || year[3:0] == 4'h6));
      case (month)
         8'h02: days_in_month = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
         default: days_in_month = 8'h31;
      endcase
   endfunction

   assign clock_write_enable = calib_config_r[rcv_pkg::CAL_WREN_BIT];
   assign access   = psel && penable;
   assign wr_year  = access && pwrite && paddr == rcv_pkg::ADDR_YEAR_VALUE && clock_write_enable;
   assign wr_month_day_value = access && pwrite && paddr == rcv_pkg::ADDR_MONTH_DAY && clock_write_enable;

   // The write enable bit is set only by an explicit write and held until cleared by software or by reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calib_config_r <= rcv_pkg::CALIB_CONFIG_RESET;
      end else if (access && pwrite && paddr == rcv_pkg::ADDR_CALIB_CONFIG) begin
         calib_config_r <= pwdata[15:0] & rcv_pkg::CALIB_CONFIG_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_config_r <= rcv_pkg::PAD_CONFIG_RESET;
      end else if (access && pwrite && paddr == rcv_pkg::ADDR_PAD_CONFIG) begin
         pad_config_r <= pwdata[15:0] & rcv_pkg::PAD_CONFIG_MASK;
      end
   end

   // Half-second prescaler; the timekeeping runs only while the enable bit is set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt_r  <= 32'h00000000;
         half_tick_r <= 1'b0;
         sec_phase_r <= 1'b0;
      end else if (!calib_config_r[rcv_pkg::CAL_EN_BIT]) begin
         half_cnt_r  <= 32'h00000000;
         half_tick_r <= 1'b0;
      end else if (half_cnt_r == 32'(HALF_SEC_CYCLES - 1)) begin
         half_cnt_r  <= 32'h00000000;
         half_tick_r <= 1'b1;
         sec_phase_r <= ~sec_phase_r;
      end else begin
         half_cnt_r  <= half_cnt_r + 32'h00000001;
         half_tick_r <= 1'b0;
      end
   end

   // A day advance is left to the time-of-day core; here it is approximated by one full second wrap.
   assign day_tick = half_tick_r && sec_phase_r;
   assign day_last = days_in_month(month_r, year_r);

   rcv_bcd_inc u_day (
      .value  (day_r),
      .last   (day_last),
      .first  (8'h01),
      .result (day_nxt),
      .wrap   (day_wrap)
   );

   rcv_bcd_inc u_month (
      .value  (month_r),
      .last   (rcv_pkg::LAST_MONTH),
      .first  (8'h01),
      .result (month_nxt),
      .wrap   (month_wrap)
   );

   rcv_bcd_inc u_year (
      .value  (year_r),
      .last   (rcv_pkg::LAST_YEAR),
      .first  (8'h00),
      .result (year_nxt),
      .wrap   (year_wrap)
   );

   // Value registers have no reset so that a warm reset keeps the calendar.
   always_ff @(posedge pclk) begin
      if (wr_year) begin
         year_r <= pwdata[7:0];
      end else if (day_tick && day_wrap && month_wrap) begin
         year_r <= year_nxt;
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_month_day_value) begin
         month_r <= {3'b000, pwdata[12:8]};
         day_r   <= {2'b00, pwdata[5:0]};
      end else if (day_tick) begin
         day_r <= day_nxt;
         if (day_wrap) begin
            month_r <= month_nxt;
         end
      end
   end

   always_comb begin
      case (paddr)
         rcv_pkg::ADDR_PAD_CONFIG:   rd_nxt = pad_config_r & rcv_pkg::PAD_CONFIG_MASK;
         rcv_pkg::ADDR_YEAR_VALUE:   rd_nxt = {8'h00, year_r} & rcv_pkg::YEAR_MASK;
         rcv_pkg::ADDR_MONTH_DAY:    rd_nxt = {3'b000, month_r[4:0], 2'b00, day_r[5:0]};
         rcv_pkg::ADDR_CALIB_CONFIG: rd_nxt = calib_config_r;
         default:                    rd_nxt = 16'h0000;
      endcase
   end

   // Zero-wait slave: pready rises in the access cycle, registered from the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && paddr > rcv_pkg::ADDR_CALIB_CONFIG;
         if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rd_nxt};
         end
      end
   end

   // The alarm arrives from another block's clock and is synchronised before use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_s1_r  <= 1'b0;
         alarm_s2_r  <= 1'b0;
         alarm_lvl_r <= 1'b0;
      end else begin
         alarm_s1_r  <= alarm_event;
         alarm_s2_r  <= alarm_s1_r;
         alarm_lvl_r <= alarm_s2_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_out                   <= 1'b0;
         clock_out_en_n              <= 1'b1;
         parport_input_buffer_select <= 1'b0;
      end else begin
         clock_out <= pad_config_r[rcv_pkg::PAD_SEC_SEL_BIT] ? sec_phase_r : alarm_lvl_r;
         clock_out_en_n <= ~calib_config_r[rcv_pkg::CAL_OE_BIT];
         parport_input_buffer_select <= pad_config_r[rcv_pkg::PAD_TTL_SEL_BIT];
      end
   end

endmodule

// ---- rcv_regs_asserts.sv ----
// Concurrent checks on the ports of the calendar value register block.
`timescale 1ns/1ps
module rcv_regs_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        alarm_event,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        clock_out,
   input wire logic        clock_out_en_n,
   input wire logic        parport_input_buffer_select
);
   logic [15:0] cal_r, pad_r, md_r;
   logic [7:0]  yr_r;
   logic        wr, rd;
   // Once timekeeping has run, the value shadows no longer track the live calendar.
   logic        run_seen_r;
   assign wr = psel && penable && pready && pwrite;
   assign rd = psel && penable && pready && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_r <= 16'h0000;
         pad_r <= 16'h0000;
      end else if (wr && paddr == rcv_pkg::ADDR_CALIB_CONFIG) begin
         cal_r <= pwdata[15:0];
      end else if (wr && paddr == rcv_pkg::ADDR_PAD_CONFIG) begin
         pad_r <= pwdata[15:0] & rcv_pkg::PAD_CONFIG_MASK;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_seen_r <= 1'b0;
      end else if (cal_r[15]) begin
         run_seen_r <= 1'b1;
      end
   end
   // The value shadows carry no reset, just like the registers they mirror.
   always_ff @(posedge pclk) begin
      if (wr && cal_r[13] && paddr == rcv_pkg::ADDR_YEAR_VALUE) begin
         yr_r <= pwdata[7:0];
      end
      if (wr && cal_r[13] && paddr == rcv_pkg::ADDR_MONTH_DAY) begin
         md_r <= pwdata[15:0] & rcv_pkg::MONTH_DAY_MASK;
      end
   end
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
   a_unmapped_err: assert property (rd && paddr > 8'h0C |-> pslverr && prdata == 32'h0) else $error("bad unmapped");
   a_year_readback: assert property (rd && paddr == 8'h04 && !run_seen_r |-> prdata == {24'h0, yr_r})
      else $error("year readback wrong");
   a_month_day_value_readback: assert property (rd && paddr == 8'h08 && !run_seen_r |-> prdata == {16'h0, md_r})
      else $error("month day readback wrong");
   a_pad_readback: assert property (rd && paddr == 8'h00 |-> prdata == {16'h0, pad_r})
      else $error("pad readback wrong");
   a_oe_follows: assert property (!$stable(cal_r[10]) |-> ##2 clock_out_en_n == !cal_r[10])
      else $error("output enable wrong");
   a_ttl_follows: assert property (!$stable(pad_r[0]) |-> ##2 parport_input_buffer_select == pad_r[0])
      else $error("buffer select wrong");
   a_alarm_route: assert property ((!pad_r[1] && $stable(alarm_event))[*6] |-> clock_out == alarm_event)
      else $error("alarm not routed");
   c_locked_write: cover property (wr && paddr == 8'h04 && !cal_r[13]);
   c_unmapped: cover property (rd && paddr > 8'h0C);
   c_tick: cover property (pad_r[1] && !$stable(clock_out));
endmodule
bind rcv_regs rcv_regs_asserts rcv_regs_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .alarm_event, .prdata, .pready, .pslverr, .clock_out, .clock_out_en_n, .parport_input_buffer_select);

// ---- tb_rcv_regs.sv ----
// Self-checking testbench for the calendar value register block.
`timescale 1ns/1ps
module tb_rcv_regs;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alarm_event = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic        pready, pslverr, clock_out, clock_out_en_n, ttl_sel, err_v;
   int          mismatches = 0;
   int          tests_run = 0;
   always #50 pclk = ~pclk;
   rcv_regs #(.HALF_SEC_CYCLES(4)) rcv_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .alarm_event, .prdata, .pready, .pslverr, .clock_out, .clock_out_en_n,
      .parport_input_buffer_select(ttl_sel));
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Called right after a rising edge; leaves one idle cycle so the next call never collides.
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_v = prdata;
      err_v = pslverr;
      if (n >= 20) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic test_reset;
      apb(1'b0, rcv_pkg::ADDR_PAD_CONFIG, 32'h0);
      check("pad reset", 32'h0, rd_v);
      apb(1'b0, rcv_pkg::ADDR_CALIB_CONFIG, 32'h0);
      check("calib reset", 32'h0, rd_v);
      check("oe reset", 32'h1, {31'h0, clock_out_en_n});
      $display("test reset done");
   endtask
   task automatic test_wren;
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h2000);
      apb(1'b1, rcv_pkg::ADDR_YEAR_VALUE, 32'hFF47);
      apb(1'b1, rcv_pkg::ADDR_MONTH_DAY, 32'hF2F1);
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h0);
      apb(1'b1, rcv_pkg::ADDR_YEAR_VALUE, 32'h0099);
      apb(1'b1, rcv_pkg::ADDR_MONTH_DAY, 32'h0101);
      apb(1'b0, rcv_pkg::ADDR_YEAR_VALUE, 32'h0);
      check("year", 32'h47, rd_v);
      apb(1'b0, rcv_pkg::ADDR_MONTH_DAY, 32'h0);
      check("month day", 32'h1231, rd_v);
      $display("test write enable done");
   endtask
   // Runs the calendar for exactly one day advance from the last day of year 99, the last year of a century.
   task automatic test_rollover;
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h2000);
      apb(1'b1, rcv_pkg::ADDR_YEAR_VALUE, 32'h0099);
      apb(1'b1, rcv_pkg::ADDR_MONTH_DAY, 32'h1231);
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'hA000);
      repeat (6) @(posedge pclk);
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h0);
      apb(1'b0, rcv_pkg::ADDR_YEAR_VALUE, 32'h0);
      check("year rollover", 32'h0, rd_v);
      apb(1'b0, rcv_pkg::ADDR_MONTH_DAY, 32'h0);
      check("month day rollover", 32'h0101, rd_v);
      $display("test rollover done");
   endtask
   task automatic test_pad;
      apb(1'b1, rcv_pkg::ADDR_PAD_CONFIG, 32'hFFFFFFFF);
      apb(1'b0, rcv_pkg::ADDR_PAD_CONFIG, 32'h0);
      check("pad", 32'h3, rd_v);
      check("ttl select", 32'h1, {31'h0, ttl_sel});
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped data", 32'h0, rd_v);
      check("unmapped err", 32'h1, {31'h0, err_v});
      apb(1'b1, rcv_pkg::ADDR_PAD_CONFIG, 32'h0);
      $display("test pad and unmapped done");
   endtask
   task automatic test_clock_out;
      int toggles;
      logic last;
      toggles = 0;
      alarm_event <= 1'b1;
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h0400);
      repeat (6) @(posedge pclk);
      check("oe on", 32'h0, {31'h0, clock_out_en_n});
      check("alarm high", 32'h1, {31'h0, clock_out});
      alarm_event <= 1'b0;
      repeat (6) @(posedge pclk);
      check("alarm low", 32'h0, {31'h0, clock_out});
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h8400);
      apb(1'b1, rcv_pkg::ADDR_PAD_CONFIG, 32'h2);
      last = clock_out;
      repeat (24) begin
         @(posedge pclk);
         if (clock_out !== last) toggles++;
         last = clock_out;
      end
      check("tick toggles", 32'h1, {31'h0, toggles >= 4});
      apb(1'b1, rcv_pkg::ADDR_CALIB_CONFIG, 32'h0);
      repeat (3) @(posedge pclk);
      check("oe off", 32'h1, {31'h0, clock_out_en_n});
      $display("test clock output done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_reset;
      test_wren;
      test_rollover;
      test_pad;
      test_clock_out;
      complete_run;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      mismatches++;
      complete_run;
   end
endmodule
